// ===== iiwf_pkg.sv
// Purpose: Constants of the interrupt and third warning filter block.
// Assumes: 25 MHz system clock.
// Notes: Offsets are register indices on the serial port map.
package iiwf_pkg;
	localparam logic [7:0]  OFS_FILT_CFG   = 8'h0A;
	localparam logic [7:0]  OFS_IRQ_EN     = 8'h0B;
	localparam logic [7:0]  OFS_IRQ_FLAGS  = 8'h0C;
	localparam logic [15:0] RST_FILT_CFG   = 16'h80FA;
	localparam logic [15:0] RST_IRQ_EN     = 16'h4000;
	localparam logic [15:0] RST_IRQ_FLAGS  = 16'h0000;
	localparam logic [15:0] WMASK_FILT_CFG = 16'hDFFF;
	localparam logic [15:0] WMASK_FLAGS    = 16'h7FFF;
	localparam int          BIT_PATH_EN    = 15;
	localparam int          BIT_COUNT_UD   = 14;
	localparam int          BIT_SAMPLE_EN  = 15;
	localparam int          BIT_RST_DONE   = 14;
	localparam int          LEN_W          = 13;
	localparam int          CLK_PERIOD_NS  = 40;
	localparam int          UNIT_TIME_NS   = 20000;
	localparam int          UNIT_CYCLES    = UNIT_TIME_NS / CLK_PERIOD_NS;
	localparam logic [8:0]  UNIT_LAST      = 9'(UNIT_CYCLES - 1);
	localparam logic [8:0]  RST_PRE        = 9'h000;
endpackage

// ===== iiwf_filt_if.sv
// Purpose: Carries the third warning filter settings and levels.
// Assumes: One clock domain.
// Notes: Two channels share one setting.
`timescale 1ns/1ns
interface iiwf_filt_if;
	logic                          path_en;
	logic                          count_ud;
	logic [iiwf_pkg::LEN_W-1:0]    len;
	logic                          tick;
	logic [1:0]                    raw;
	logic [1:0]                    filt;
	modport ctrl (output path_en, output count_ud, output len, output tick, output raw, input filt);
	modport filt_side (input path_en, input count_ud, input len, input tick, input raw, output filt);
endinterface

// ===== iiwf_debounce.sv
// Purpose: Debounces the third warning comparator of both channels.
// Assumes: Tick is a one-cycle pulse each length unit.
// Notes: Zero length passes the input straight through.
`timescale 1ns/1ns
module iiwf_debounce (
	input  wire logic  clk_sys,
	input  wire logic  rst,
	iiwf_filt_if.filt_side f
);
	logic [iiwf_pkg::LEN_W-1:0] cnt_q [2];
	logic [iiwf_pkg::LEN_W-1:0] cnt_d [2];
	logic [1:0]                 st_q;
	logic [1:0]                 st_d;
	logic                       bypass;

	assign bypass = (f.len == '0);

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			cnt_d[i] = cnt_q[i];
			st_d[i]  = st_q[i];
			if (!f.path_en || bypass) begin
				cnt_d[i] = '0;
				st_d[i]  = f.path_en & f.raw[i];
			end else if (f.count_ud) begin
				if (f.tick) begin
					if (f.raw[i] && cnt_q[i] < f.len)
						cnt_d[i] = cnt_q[i] + 13'h0001;
					else if (!f.raw[i] && cnt_q[i] != '0)
						cnt_d[i] = cnt_q[i] - 13'h0001;
					if (cnt_d[i] >= f.len)
						st_d[i] = 1'b1;
					else if (cnt_d[i] == '0)
						st_d[i] = 1'b0;
				end
			end else if (f.raw[i] == st_q[i]) begin
				cnt_d[i] = '0;
			end else if (f.tick) begin
				cnt_d[i] = cnt_q[i] + 13'h0001;
				if (cnt_d[i] >= f.len) begin
					st_d[i]  = f.raw[i];
					cnt_d[i] = '0;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt_q <= '{default: '0};
			st_q  <= 2'h0;
		end else begin
			cnt_q <= cnt_d;
			st_q  <= st_d;
		end
	end

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			if (!f.path_en)
				f.filt[i] = 1'b0;
			else if (bypass)
				f.filt[i] = f.raw[i];
			else
				f.filt[i] = st_q[i];
		end
	end

	bypass_path_a: assert property (@(posedge clk_sys) disable iff (rst)
		f.path_en && bypass |-> f.filt == f.raw) else $error("bypass output differs from input");
	held_low_a: assert property (@(posedge clk_sys) disable iff (rst)
		!f.path_en |-> f.filt == 2'h0) else $error("disabled path not low");
	glitch_reject_a: assert property (@(posedge clk_sys) disable iff (rst)
		f.path_en && !bypass && !f.count_ud && !f.tick |=> $stable(st_q)) else $error("output moved without tick");
endmodule // iiwf_debounce

// ===== iiwf_top.sv
// Purpose: Interrupt enable, event flags and third warning filter setup.
// Assumes: Register port strobes are single-cycle and synchronous.
// Notes: Lock blocks writes except to the flag register.
`timescale 1ns/1ns
module iiwf_top (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	input  wire logic        cfg_lock,
	input  wire logic        sample_ready,
	input  wire logic        link_busy,
	input  wire logic        ch1_thermal_backoff,
	input  wire logic        ch2_thermal_backoff,
	input  wire logic        load_overtemp_flag,
	input  wire logic        isolation_link_fault,
	input  wire logic        register_mismatch_fault,
	input  wire logic        ch1_first_warning,
	input  wire logic        ch1_second_warning,
	input  wire logic        ch1_third_warning,
	input  wire logic        ch2_first_warning,
	input  wire logic        ch2_second_warning,
	input  wire logic        ch2_third_warning,
	input  wire logic        ch1_filtered_output,
	input  wire logic        ch2_filtered_output,
	output logic             irq
);
	logic [15:0] filt_cfg_q;
	logic [15:0] filt_cfg_d;
	logic [15:0] irq_en_q;
	logic [15:0] irq_en_d;
	logic [15:0] flags_q;
	logic [15:0] flags_d;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;
	logic        irq_q;
	logic        irq_d;
	logic        done_pend_q;
	logic        done_pend_d;
	logic [8:0]  pre_q;
	logic [8:0]  pre_d;
	logic [7:0]  lvl_prev_q;
	logic [7:0]  lvl_prev_d;
	logic [7:0]  lvl_now;
	logic [7:0]  lvl_rise;
	logic [15:0] ev;
	logic [15:0] clr;
	logic [15:0] kept;

	iiwf_filt_if fif ();

	function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] ofs, input logic w);
		return w && (a == ofs);
	endfunction

	assign fif.path_en  = filt_cfg_q[iiwf_pkg::BIT_PATH_EN];
	assign fif.count_ud = filt_cfg_q[iiwf_pkg::BIT_COUNT_UD];
	assign fif.len      = filt_cfg_q[iiwf_pkg::LEN_W-1:0];
	assign fif.tick     = (pre_q == iiwf_pkg::UNIT_LAST);
	assign fif.raw      = {ch2_third_warning, ch1_third_warning};

	iiwf_debounce u_debounce (
		.clk_sys (clk_sys),
		.rst     (rst),
		.f       (fif.filt_side)
	);

	// Levels whose rising edges are events: c2 b2 a2 out2 c1 b1 a1 out1.
	assign lvl_now  = {fif.filt[1], ch2_second_warning, ch2_first_warning, ch2_filtered_output,
	                   fif.filt[0], ch1_second_warning, ch1_first_warning, ch1_filtered_output};
	assign lvl_rise = lvl_now & ~lvl_prev_q;

	assign ev = {1'b0, done_pend_q, link_busy, ch2_thermal_backoff, ch1_thermal_backoff,
	             load_overtemp_flag, isolation_link_fault, register_mismatch_fault,
	             lvl_rise};

	assign clr = wr_hit(reg_addr, iiwf_pkg::OFS_IRQ_FLAGS, reg_wr) ? reg_wdata : 16'h0000;
	assign kept = flags_q & ~clr;

	always_comb begin
		pre_d       = (pre_q == iiwf_pkg::UNIT_LAST) ? 9'h000 : pre_q + 9'h001;
		done_pend_d = 1'b0;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pre_q       <= iiwf_pkg::RST_PRE;
			done_pend_q <= 1'b1;
		end else begin
			pre_q       <= pre_d;
			done_pend_q <= done_pend_d;
		end
	end

	always_comb begin
		filt_cfg_d = filt_cfg_q;
		irq_en_d   = irq_en_q;
		if (wr_hit(reg_addr, iiwf_pkg::OFS_FILT_CFG, reg_wr && !cfg_lock))
			filt_cfg_d = reg_wdata & iiwf_pkg::WMASK_FILT_CFG;
		if (wr_hit(reg_addr, iiwf_pkg::OFS_IRQ_EN, reg_wr && !cfg_lock))
			irq_en_d = reg_wdata;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			filt_cfg_q <= iiwf_pkg::RST_FILT_CFG;
			irq_en_q   <= iiwf_pkg::RST_IRQ_EN;
		end else begin
			filt_cfg_q <= filt_cfg_d;
			irq_en_q   <= irq_en_d;
		end
	end

	always_comb begin
		lvl_prev_d = lvl_now;
		// Set wins over a write-one clear in the same cycle.
		flags_d    = ((flags_q & ~clr) | ev) & iiwf_pkg::WMASK_FLAGS;
		irq_d      = (|(flags_q & irq_en_q & iiwf_pkg::WMASK_FLAGS))
		           | (irq_en_q[iiwf_pkg::BIT_SAMPLE_EN] & sample_ready);
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lvl_prev_q <= 8'h00;
			flags_q    <= iiwf_pkg::RST_IRQ_FLAGS;
			irq_q      <= 1'b0;
		end else begin
			lvl_prev_q <= lvl_prev_d;
			flags_q    <= flags_d;
			irq_q      <= irq_d;
		end
	end

	always_comb begin
		rdata_d = rdata_q;
		if (reg_rd) begin
			unique case (reg_addr)
				iiwf_pkg::OFS_FILT_CFG:  rdata_d = filt_cfg_q;
				iiwf_pkg::OFS_IRQ_EN:    rdata_d = irq_en_q;
				iiwf_pkg::OFS_IRQ_FLAGS: rdata_d = flags_q;
				default:                 rdata_d = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdata_q <= 16'h0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign irq       = irq_q;
	assign reg_rdata = rdata_q;

	event_sets_a: assert property (@(posedge clk_sys) disable iff (rst)
		ev != 16'h0000 |=> (flags_q & $past(ev)) == $past(ev)) else $error("event did not set its flag");
	w1c_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_wr && reg_addr == iiwf_pkg::OFS_IRQ_FLAGS && ev == 16'h0000)
		|=> (flags_q & $past(reg_wdata)) == 16'h0000) else $error("write one did not clear flag");
	irq_level_a: assert property (@(posedge clk_sys) disable iff (rst)
		(flags_q & irq_en_q & iiwf_pkg::WMASK_FLAGS) != 16'h0000 |=> irq_q) else $error("enabled flag gave no irq");
	irq_masked_a: assert property (@(posedge clk_sys) disable iff (rst)
		(flags_q & irq_en_q & iiwf_pkg::WMASK_FLAGS) == 16'h0000 && !sample_ready |=> !irq_q)
		else $error("irq without enabled flag");
	sample_irq_a: assert property (@(posedge clk_sys) disable iff (rst)
		irq_en_q[iiwf_pkg::BIT_SAMPLE_EN] && sample_ready |=> irq_q) else $error("sample ready irq missing");
	reset_done_a: assert property (@(posedge clk_sys) disable iff (rst)
		done_pend_q |=> flags_q[iiwf_pkg::BIT_RST_DONE] ##0 !done_pend_q) else $error("reset done flag missing");
	lock_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
		cfg_lock && reg_wr |=> $stable(irq_en_q) && $stable(filt_cfg_q)) else $error("locked write changed config");
	warn_rise_a: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(ch1_first_warning) |=> flags_q[1]) else $error("warning rise not flagged");
	unit_tick_a: assert property (@(posedge clk_sys) disable iff (rst)
		fif.tick |=> !fif.tick [*8]) else $error("length unit tick too frequent");
	cool_ch1_a: assert property (@(posedge clk_sys) disable iff (rst)
		ch1_thermal_backoff |=> flags_q[11]) else $error("channel 1 cool-down not flagged");
	cool_ch2_a: assert property (@(posedge clk_sys) disable iff (rst)
		ch2_thermal_backoff |=> flags_q[12]) else $error("channel 2 cool-down not flagged");
	overtemp_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
		load_overtemp_flag |=> flags_q[10]) else $error("thermal shutdown not flagged");
	link_fault_a: assert property (@(posedge clk_sys) disable iff (rst)
		isolation_link_fault |=> flags_q[9]) else $error("link fault not flagged");
	copy_fault_a: assert property (@(posedge clk_sys) disable iff (rst)
		register_mismatch_fault |=> flags_q[8]) else $error("copy mismatch not flagged");
	ch1_out_a: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(ch1_filtered_output) |=> flags_q[0]) else $error("channel 1 output rise not flagged");
	ch2_out_a: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(ch2_filtered_output) |=> flags_q[4]) else $error("channel 2 output rise not flagged");
	third_rise_a: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(fif.filt[1]) |=> flags_q[7]) else $error("third warning rise not flagged");
	flag_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
		kept != 16'h0000 |=> (flags_q & $past(kept)) == $past(kept)) else $error("flag lost without write one");
	en_write_a: assert property (@(posedge clk_sys) disable iff (rst)
		reg_wr && !cfg_lock && reg_addr == iiwf_pkg::OFS_IRQ_EN |=> irq_en_q == $past(reg_wdata))
		else $error("enable write lost");
	cfg_write_a: assert property (@(posedge clk_sys) disable iff (rst)
		reg_wr && !cfg_lock && reg_addr == iiwf_pkg::OFS_FILT_CFG
		|=> filt_cfg_q == ($past(reg_wdata) & iiwf_pkg::WMASK_FILT_CFG)) else $error("filter setup write lost");
	flag_read_a: assert property (@(posedge clk_sys) disable iff (rst)
		reg_rd && reg_addr == iiwf_pkg::OFS_IRQ_FLAGS
		|=> reg_rdata == $past(flags_q)) else $error("flag read wrong");
endmodule // iiwf_top

// ===== iiwf_host.sv
// Purpose: Host side of the register port.
// Assumes: Strobes change on the falling edge.
// Notes: Released lines carry inverted values.
`timescale 1ns/1ns
module iiwf_host (
	input  wire logic        clk_sys,
	output logic      [7:0]  reg_addr,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic      [15:0] reg_wdata,
	input  wire logic [15:0] reg_rdata
);
	initial begin
		reg_addr = 8'hFF;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 16'h0000;
	end
	// Writing one clears a flag.
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk_sys);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk_sys);
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask
endmodule // iiwf_host

// ===== tb.sv
// Purpose: Self-checking bench of the interrupt and filter block.
// Assumes: Inputs change on the falling edge.
// Notes: Filter unit is 500 cycles.
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; $display("FAIL %0t got %h exp %h", $time, g, e); end end
module tb;
	logic        clk_sys;
	logic        rst;
	logic [7:0]  reg_addr;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic        cfg_lock;
	logic        sample_ready;
	logic [13:0] ev;
	logic        irq;
	logic [15:0] d;
	int          num_errors = 0;
	int          checked = 0;
	iiwf_host host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	iiwf_top dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cfg_lock(cfg_lock), .sample_ready(sample_ready),
		.link_busy(ev[13]), .ch2_thermal_backoff(ev[12]), .ch1_thermal_backoff(ev[11]),
		.load_overtemp_flag(ev[10]), .isolation_link_fault(ev[9]), .register_mismatch_fault(ev[8]),
		.ch2_third_warning(ev[7]), .ch2_second_warning(ev[6]), .ch2_first_warning(ev[5]),
		.ch2_filtered_output(ev[4]), .ch1_third_warning(ev[3]), .ch1_second_warning(ev[2]),
		.ch1_first_warning(ev[1]), .ch1_filtered_output(ev[0]), .irq(irq));
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	task automatic summarize();
		if (num_errors == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
		host.rd(a, d);
		`CHK(d, e)
	endtask
	task automatic t_reset();
		rdchk(iiwf_pkg::OFS_IRQ_EN, 16'h4000);
		rdchk(iiwf_pkg::OFS_FILT_CFG, 16'h80FA);
		rdchk(iiwf_pkg::OFS_IRQ_FLAGS, 16'h4000);
		`CHK(irq, 1'b1)
	endtask
	task automatic t_lock();
		cfg_lock = 1'b1;
		host.wr(iiwf_pkg::OFS_IRQ_EN, 16'hFFFF);
		rdchk(iiwf_pkg::OFS_IRQ_EN, 16'h4000);
		host.wr(iiwf_pkg::OFS_IRQ_FLAGS, 16'h4000);
		rdchk(iiwf_pkg::OFS_IRQ_FLAGS, 16'h0000);
		`CHK(irq, 1'b0)
		cfg_lock = 1'b0;
		rdchk(8'h3F, 16'h0000);
	endtask
	task automatic t_events();
		host.wr(iiwf_pkg::OFS_FILT_CFG, 16'h8000);
		host.wr(iiwf_pkg::OFS_IRQ_EN, 16'h3FFF);
		for (int i = 0; i < 14; i++) begin
			ev[i] = 1'b1;
			@(negedge clk_sys);
			ev[i] = 1'b0;
			repeat (2) @(negedge clk_sys);
			`CHK(irq, 1'b1)
			rdchk(iiwf_pkg::OFS_IRQ_FLAGS, 16'h0001 << i);
			host.wr(iiwf_pkg::OFS_IRQ_FLAGS, 16'h0001 << i);
			@(negedge clk_sys);
			`CHK(irq, 1'b0)
		end
		host.wr(iiwf_pkg::OFS_IRQ_EN, 16'h0000);
		ev[1] = 1'b1;
		repeat (4) @(negedge clk_sys);
		`CHK(irq, 1'b0)
		ev[1] = 1'b0;
		rdchk(iiwf_pkg::OFS_IRQ_FLAGS, 16'h0002);
		host.wr(iiwf_pkg::OFS_IRQ_FLAGS, 16'h0002);
	endtask
	task automatic t_filter();
		host.wr(iiwf_pkg::OFS_IRQ_EN, 16'h0008);
		host.wr(iiwf_pkg::OFS_FILT_CFG, 16'h8002);
		ev[3] = 1'b1;
		repeat (300) @(negedge clk_sys);
		ev[3] = 1'b0;
		repeat (1200) @(negedge clk_sys);
		rdchk(iiwf_pkg::OFS_IRQ_FLAGS, 16'h0000);
		ev[3] = 1'b1;
		repeat (1100) @(negedge clk_sys);
		`CHK(irq, 1'b1)
		ev[3] = 1'b0;
		repeat (1100) @(negedge clk_sys);
		host.wr(iiwf_pkg::OFS_IRQ_FLAGS, 16'h0008);
		host.wr(iiwf_pkg::OFS_FILT_CFG, 16'h0000);
		ev[3] = 1'b1;
		repeat (4) @(negedge clk_sys);
		rdchk(iiwf_pkg::OFS_IRQ_FLAGS, 16'h0000);
		ev[3] = 1'b0;
		host.wr(iiwf_pkg::OFS_FILT_CFG, 16'hE001);
		rdchk(iiwf_pkg::OFS_FILT_CFG, 16'hC001);
		ev[3] = 1'b1;
		repeat (600) @(negedge clk_sys);
		rdchk(iiwf_pkg::OFS_IRQ_FLAGS, 16'h0008);
		ev[3] = 1'b0;
		repeat (600) @(negedge clk_sys);
		host.wr(iiwf_pkg::OFS_IRQ_FLAGS, 16'h0008);
	endtask
	task automatic t_sample();
		host.wr(iiwf_pkg::OFS_IRQ_EN, 16'h8000);
		sample_ready = 1'b1;
		@(negedge clk_sys);
		sample_ready = 1'b0;
		`CHK(irq, 1'b1)
		@(negedge clk_sys);
		`CHK(irq, 1'b0)
	endtask
	task automatic t_relink();
		host.wr(iiwf_pkg::OFS_IRQ_EN, 16'h0200);
		ev[9] = 1'b1;
		@(negedge clk_sys);
		ev[9] = 1'b0;
		host.wr(iiwf_pkg::OFS_IRQ_FLAGS, 16'h0200);
		ev[9] = 1'b1;
		@(negedge clk_sys);
		ev[9] = 1'b0;
		repeat (2) @(negedge clk_sys);
		`CHK(irq, 1'b1)
		rdchk(iiwf_pkg::OFS_IRQ_FLAGS, 16'h0200);
		host.wr(iiwf_pkg::OFS_FILT_CFG, iiwf_pkg::RST_FILT_CFG);
		host.wr(iiwf_pkg::OFS_IRQ_EN, 16'h0200);
		rdchk(iiwf_pkg::OFS_FILT_CFG, 16'h80FA);
		rdchk(iiwf_pkg::OFS_IRQ_EN, 16'h0200);
		host.wr(iiwf_pkg::OFS_IRQ_FLAGS, 16'h0200);
		rdchk(iiwf_pkg::OFS_IRQ_FLAGS, 16'h0000);
	endtask
	task automatic t_rerun();
		host.wr(iiwf_pkg::OFS_FILT_CFG, 16'h0005);
		rst = 1'b1;
		@(negedge clk_sys);
		`CHK(irq, 1'b0)
		`CHK(reg_rdata, 16'h0000)
		rst = 1'b0;
		repeat (2) @(negedge clk_sys);
		`CHK(irq, 1'b1)
		rdchk(iiwf_pkg::OFS_FILT_CFG, 16'h80FA);
		rdchk(iiwf_pkg::OFS_IRQ_EN, 16'h4000);
		rdchk(iiwf_pkg::OFS_IRQ_FLAGS, 16'h4000);
	endtask
	initial begin
		#1ms;
		num_errors++;
		summarize();
	end
	initial begin
		rst = 1'b1;
		cfg_lock = 1'b0;
		sample_ready = 1'b0;
		ev = 14'h0000;
		repeat (3) @(negedge clk_sys);
		rst = 1'b0;
		repeat (2) @(negedge clk_sys);
		t_reset();
		t_lock();
		t_events();
		t_filter();
		t_relink();
		t_sample();
		t_rerun();
		summarize();
	end
endmodule // tb
